//--- verilog/psd_defines.vh
`ifndef PSD_DEFINES_VH
`define PSD_DEFINES_VH

// register offsets on the plain register port
`define PSD_ADDR_RESTART_DB 4'h0
`define PSD_ADDR_STEER 4'h1
`define PSD_ADDR_SHUTDOWN 4'h2
`define PSD_ADDR_IRQ_STATUS 4'h3
`define PSD_ADDR_IRQ_ENABLE 4'h4
`define PSD_ADDR_IRQ_CLEAR 4'h5

// restart_and_deadband_control fields
`define PSD_RESTART_BIT 7
`define PSD_DB_MSB 6
`define PSD_DB_LSB 0
`define PSD_RESTART_DB_RESET 8'h00

// pulse_steering_control fields
`define PSD_CMPL_MSB 7
`define PSD_CMPL_LSB 6
`define PSD_STEER_UNUSED_BIT 5
`define PSD_SYNC_BIT 4
`define PSD_STEER_MSB 3
`define PSD_STEER_LSB 0
`define PSD_STEER_RESET 8'h01
`define PSD_STEER_WMASK 8'hdf

// shutdown register: event status in bit 7
`define PSD_SHUTDOWN_BIT 7

// interrupt status layout
`define PSD_IRQ_SHUTDOWN 0
`define PSD_IRQ_RESTART 1
`define PSD_IRQ_OSC_FAIL 2
`define PSD_IRQ_WIDTH 3

// mode decode
`define PSD_MODE_PWM 2'h3
`define PSD_CFG_SINGLE 2'h0
`define PSD_CMPL_STEER 2'h0
`define PSD_CMPL_AB 2'h1
`define PSD_CMPL_AC 2'h2
`define PSD_CMPL_AD 2'h3

// shutdown pin state codes
`define PSD_SD_LOW 2'h0
`define PSD_SD_HIGH 2'h1

// one instruction cycle is four oscillator periods
`define PSD_CLK_PER_TCY 4

`endif

//--- verilog/psd_steer.v
`timescale 1ns/1ps
`default_nettype none
`include "psd_defines.vh"

// Summary of operation
// [R1] auto restart: hardware clears shutdown status when condition goes, PWM resumes
// [R2] without auto restart, software clears shutdown status before outputs resume
// [R3] inactive-to-active edge delayed by dead-band count instruction cycles
// [R4] steering works only with mode upper bits 11 and single output config 00
// [R5] each steer enable drives its pin with polarised PWM, else pin is port
// [R6] pair select: 00 steer bits, 01 A/B, 10 A/C, 11 A/D
// [R7] sync clear: new steering applies right after the register write
// [R8] sync set: new steering applies at the next period start
// [R9] shutdown forces only PWM-carrying pins, port pins untouched
// [R10] pin driven only when its direction bit is zero (output)
// [R11] software must enable at least one steer bit to see the waveform
// [R12] unimplemented steering bit 5 always reads zero
// [R13] during sleep all state freezes and pins hold their levels; read data still updates on a read strobe here
// [R14] primary idle: module keeps running unchanged
// [R15] on clock failure keep running and raise oscillator fail flag
// [R16] reset restores register defaults and releases all pins to input
// [R17] after shutdown clears, waveform restarts only at next period start
// [R18] dead band only on inactive-to-active, never on active-to-inactive
// [R19] dead-band count zero inserts no delay
module psd_steer #(
    parameter DB_WIDTH = 7,
    parameter CLK_PER_TCY = `PSD_CLK_PER_TCY
) (
    // clock and reset
    input wire clock,
    input wire resetn,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // waveform source, same clock domain
    input wire pwm_raw,
    input wire period_start,
    // configuration from the capture/compare control
    input wire [3:0] capture_compare_mode_field,
    input wire [1:0] output_config_field,
    input wire [1:0] shutdown_state_ac,
    input wire [1:0] shutdown_state_bd,
    input wire [3:0] pin_direction_bit,
    // asynchronous shutdown condition level
    input wire shutdown_condition,
    // power management, same clock domain
    input wire sleep_mode,
    input wire clock_fail_detect,
    // pins a..d: output, output enable
    output reg pwm_out_a,
    output reg pwm_out_b,
    output reg pwm_out_c,
    output reg pwm_out_d,
    output reg pwm_oe_a,
    output reg pwm_oe_b,
    output reg pwm_oe_c,
    output reg pwm_oe_d,
    // status and interrupt
    output reg osc_fail_flag,
    output wire irq
);

    reg auto_restart_enable;
    reg [DB_WIDTH-1:0] dead_band_count;
    reg [1:0] complementary_pair_select;
    reg steer_update_sync;
    reg [3:0] steer_enable;
    reg [1:0] pair_eff;
    reg [3:0] steer_eff;
    reg pending;
    reg shutdown_event_status;
    reg shutdown_hold;
    reg [`PSD_IRQ_WIDTH-1:0] irq_status;
    reg [`PSD_IRQ_WIDTH-1:0] irq_enable;
    reg sd_meta;
    reg sd_sync;
    reg raw_q;
    reg prim_on;
    reg comp_on;
    reg [DB_WIDTH+2:0] prim_cnt;
    reg [DB_WIDTH+2:0] comp_cnt;
    wire run;
    wire wr_steer;
    wire wr_sd;
    wire mode_ok;
    wire [DB_WIDTH+2:0] db_cycles;
    wire [7:0] steer_word;
    reg [3:0] carry;
    reg [3:0] use_comp;
    reg [3:0] next_out;
    reg [3:0] next_oe;
    reg [1:0] sd_code;
    reg level;
    reg [`PSD_IRQ_WIDTH-1:0] next_irq;
    reg next_sd;
    integer i;

    // freeze all but read data while asleep; idle keeps running [R13] [R14]
    assign run = ~sleep_mode;
    assign wr_steer = reg_write && reg_addr == `PSD_ADDR_STEER;
    assign wr_sd = reg_write && reg_addr == `PSD_ADDR_SHUTDOWN;
    // steering only in pwm mode with single output config [R4]
    assign mode_ok = capture_compare_mode_field[3:2] == `PSD_MODE_PWM &&
        output_config_field == `PSD_CFG_SINGLE;
    // dead band in clocks: count times four [R3]
    assign db_cycles = {3'h0, dead_band_count} *
        CLK_PER_TCY[DB_WIDTH+2:0];
    assign steer_word = {complementary_pair_select, 1'b0,
        steer_update_sync, steer_enable};
    assign irq = |(irq_status & irq_enable);

    // shutdown level passes two flip-flops before use
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
        end else if (run) begin
            sd_meta <= shutdown_condition;
            sd_sync <= sd_meta;
        end
    end

    // software registers [R16]
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            auto_restart_enable <= 1'b0;
            dead_band_count <= {DB_WIDTH{1'b0}};
            complementary_pair_select <= 2'h0;
            steer_update_sync <= 1'b0;
            steer_enable <= 4'h1;
            irq_enable <= {`PSD_IRQ_WIDTH{1'b0}};
        end else if (run && reg_write) begin
            case (reg_addr)
                `PSD_ADDR_RESTART_DB: begin
                    auto_restart_enable <= reg_wdata[`PSD_RESTART_BIT];
                    dead_band_count <= reg_wdata[DB_WIDTH-1:0];
                end
                `PSD_ADDR_STEER: begin
                    complementary_pair_select <=
                        reg_wdata[`PSD_CMPL_MSB:`PSD_CMPL_LSB];
                    steer_update_sync <= reg_wdata[`PSD_SYNC_BIT];
                    steer_enable <=
                        reg_wdata[`PSD_STEER_MSB:`PSD_STEER_LSB];
                end
                `PSD_ADDR_IRQ_ENABLE: begin
                    irq_enable <= reg_wdata[`PSD_IRQ_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // effective steering: immediate or at next period start [R7] [R8]
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            steer_eff <= 4'h1;
            pair_eff <= 2'h0;
            pending <= 1'b0;
        end else if (run) begin
            if (wr_steer && !reg_wdata[`PSD_SYNC_BIT]) begin
                steer_eff <= reg_wdata[`PSD_STEER_MSB:`PSD_STEER_LSB]; // [R7]
                pair_eff <= reg_wdata[`PSD_CMPL_MSB:`PSD_CMPL_LSB];
                pending <= 1'b0;
            end else if (wr_steer) begin
                pending <= 1'b1; // [R8]
            end else if (pending && period_start) begin
                steer_eff <= steer_enable; // [R8]
                pair_eff <= complementary_pair_select;
                pending <= 1'b0;
            end
        end
    end

    // shutdown status: condition sets, restart or software clears
    always @* begin
        next_sd = shutdown_event_status;
        if (wr_sd && !sd_sync) begin
            next_sd = reg_wdata[`PSD_SHUTDOWN_BIT]; // [R2]
        end
        if (auto_restart_enable && !sd_sync) begin
            next_sd = 1'b0; // [R1]
        end
        if (sd_sync) begin
            next_sd = 1'b1; // set wins over any clear
        end
    end

    // outputs stay shut until a period start after status clears [R17]
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shutdown_event_status <= 1'b0;
            shutdown_hold <= 1'b0;
        end else if (run) begin
            shutdown_event_status <= next_sd;
            if (next_sd) begin
                shutdown_hold <= 1'b1;
            end else if (period_start) begin
                shutdown_hold <= 1'b0; // [R17]
            end
        end
    end

    // interrupt events; set wins over a clear in the same cycle
    always @* begin
        next_irq = irq_status;
        if (reg_write && reg_addr == `PSD_ADDR_IRQ_CLEAR) begin
            next_irq = irq_status & ~reg_wdata[`PSD_IRQ_WIDTH-1:0];
        end
        if (next_sd && !shutdown_event_status) begin
            next_irq[`PSD_IRQ_SHUTDOWN] = 1'b1;
        end
        if (shutdown_hold && !next_sd && period_start) begin
            next_irq[`PSD_IRQ_RESTART] = 1'b1;
        end
        if (clock_fail_detect) begin
            next_irq[`PSD_IRQ_OSC_FAIL] = 1'b1;
        end
    end

    // clock failure raises the flag; logic keeps running [R15]
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_status <= {`PSD_IRQ_WIDTH{1'b0}};
            osc_fail_flag <= 1'b0;
        end else if (run) begin
            irq_status <= next_irq;
            if (clock_fail_detect) begin
                osc_fail_flag <= 1'b1; // [R15]
            end
        end
    end

    // dead band on rising edges of the waveform and its complement
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            raw_q <= 1'b0;
            prim_on <= 1'b0;
            comp_on <= 1'b0;
            prim_cnt <= {(DB_WIDTH+3){1'b0}};
            comp_cnt <= {(DB_WIDTH+3){1'b0}};
        end else if (run) begin
            raw_q <= pwm_raw;
            if (!pwm_raw) begin
                prim_on <= 1'b0; // falling edge passes undelayed [R18]
            end else if (!raw_q) begin
                prim_cnt <= db_cycles; // [R3]
                prim_on <= db_cycles == {(DB_WIDTH+3){1'b0}}; // [R19]
            end else if (prim_cnt > {(DB_WIDTH+3){1'b0}}) begin
                prim_cnt <= prim_cnt - 1'b1;
                prim_on <= prim_cnt == {{(DB_WIDTH+2){1'b0}}, 1'b1};
            end
            // the complement starts its dead band whenever it is idle
            // and raw is low, not on a raw fall: after reset raw sits
            // low and an edge detector would never see it turn on
            if (pwm_raw) begin
                comp_on <= 1'b0; // [R18]
                comp_cnt <= {(DB_WIDTH+3){1'b0}};
            end else if (!comp_on && comp_cnt == {(DB_WIDTH+3){1'b0}}) begin
                comp_cnt <= db_cycles; // [R3]
                comp_on <= db_cycles == {(DB_WIDTH+3){1'b0}}; // [R19]
            end else if (comp_cnt > {(DB_WIDTH+3){1'b0}}) begin
                comp_cnt <= comp_cnt - 1'b1;
                comp_on <= comp_cnt == {{(DB_WIDTH+2){1'b0}}, 1'b1};
            end
        end
    end

    // pins carrying the waveform from pair select or steer bits [R6]
    always @* begin
        carry = 4'h0;
        use_comp = 4'h0;
        case (pair_eff)
            `PSD_CMPL_STEER: begin
                carry = steer_eff; // [R5] [R11]
            end
            `PSD_CMPL_AB: begin
                carry = 4'h3;
                use_comp = 4'h2;
            end
            `PSD_CMPL_AC: begin
                carry = 4'h5;
                use_comp = 4'h4;
            end
            `PSD_CMPL_AD: begin
                carry = 4'h9;
                use_comp = 4'h8;
            end
            default: begin
                carry = 4'h0;
            end
        endcase
        if (!mode_ok) begin
            carry = 4'h0; // [R4]
        end
    end

    // per-pin drive with polarity, shutdown state and direction bit
    always @* begin
        next_out = 4'h0;
        next_oe = 4'h0;
        sd_code = `PSD_SD_LOW;
        level = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            sd_code = (i == 0 || i == 2) ? shutdown_state_ac :
                shutdown_state_bd;
            level = use_comp[i] ? comp_on : prim_on;
            // a/c polarity from mode bit 1, b/d from bit 0 [R5]
            if (i == 0 || i == 2) begin
                level = level ^ capture_compare_mode_field[1];
            end else begin
                level = level ^ capture_compare_mode_field[0];
            end
            if (carry[i] && !pin_direction_bit[i]) begin // [R10]
                if (shutdown_hold) begin
                    // only carrying pins take shutdown state [R9]
                    next_oe[i] = sd_code == `PSD_SD_LOW ||
                        sd_code == `PSD_SD_HIGH;
                    next_out[i] = sd_code == `PSD_SD_HIGH;
                end else begin
                    next_oe[i] = 1'b1;
                    next_out[i] = level;
                end
            end
        end
    end

    // registered pins, released to input on reset [R16] [R13]
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= 4'h0;
            {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= 4'h0;
        end else if (run) begin
            {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= next_out;
            {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= next_oe;
        end
    end

    // read data one cycle after the read strobe
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `PSD_ADDR_RESTART_DB: begin
                    reg_rdata <= {auto_restart_enable, dead_band_count};
                end
                `PSD_ADDR_STEER: begin
                    reg_rdata <= steer_word & `PSD_STEER_WMASK; // [R12]
                end
                `PSD_ADDR_SHUTDOWN: begin
                    reg_rdata <= {shutdown_event_status, 7'h00};
                end
                `PSD_ADDR_IRQ_STATUS: begin
                    reg_rdata <= {5'h00, irq_status};
                end
                `PSD_ADDR_IRQ_ENABLE: begin
                    reg_rdata <= {5'h00, irq_enable};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // psd_steer

`default_nettype wire

//--- bench/psd_steer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module psd_steer_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // inputs that shape the pins and the clock fail flag
    input wire logic pwm_raw,
    input wire logic [3:0] capture_compare_mode_field,
    input wire logic [1:0] output_config_field,
    input wire logic [1:0] shutdown_state_ac,
    input wire logic [3:0] pin_direction_bit,
    input wire logic shutdown_condition,
    input wire logic sleep_mode,
    input wire logic clock_fail_detect,
    // pins and status
    input wire logic pwm_out_a,
    input wire logic pwm_out_b,
    input wire logic pwm_out_c,
    input wire logic pwm_out_d,
    input wire logic pwm_oe_a,
    input wire logic pwm_oe_b,
    input wire logic pwm_oe_c,
    input wire logic pwm_oe_d,
    input wire logic osc_fail_flag,
    input wire logic irq
);
    // pins gathered, pin a in bit 0
    wire [3:0] oe = {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a};
    wire [3:0] po = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // raw falls while pin a is active high, no sleep around it
    sequence s_raw_fall;
        $fell(pwm_raw) && capture_compare_mode_field == 4'hc
            && !sleep_mode ##1 !sleep_mode;
    endsequence
    // low shutdown level held past the synchroniser
    sequence s_sd_low;
        (shutdown_condition && shutdown_state_ac == 2'h0
            && !sleep_mode) [*6];
    endsequence

    a_reset_release: assert property (disable iff (1'b0)
        !resetn |-> oe == 4'h0 && !irq && !osc_fail_flag)
        else $error("pins or flags active in reset");
    a_fall_prompt: assert property (
        s_raw_fall |=> !(pwm_oe_a && pwm_out_a))
        else $error("falling edge delayed");
    a_sd_force: assert property (
        s_sd_low |-> !(pwm_oe_a && pwm_out_a) && !(pwm_oe_c && pwm_out_c))
        else $error("shutdown level not forced");
    a_sleep_hold: assert property (
        sleep_mode |=> $stable({po, oe, osc_fail_flag}))
        else $error("state moved in sleep");
    a_dir_gate: assert property (
        $stable(pin_direction_bit) [*2] |-> (pin_direction_bit & oe) == 4'h0)
        else $error("input pin driven");
    a_mode_gate: assert property (
        !(capture_compare_mode_field[3:2] == 2'h3
        && output_config_field == 2'h0) [*2] |-> oe == 4'h0)
        else $error("pin driven outside steering mode");
    a_osc_set: assert property (
        clock_fail_detect && !sleep_mode |=> osc_fail_flag)
        else $error("clock fail flag not raised");
    a_osc_keep: assert property (
        osc_fail_flag |=> osc_fail_flag)
        else $error("clock fail flag dropped");
endmodule // psd_steer_assertions

bind psd_steer psd_steer_assertions u_psd_steer_assertions (
    .clock(clock), .resetn(resetn), .pwm_raw(pwm_raw),
    .capture_compare_mode_field(capture_compare_mode_field),
    .output_config_field(output_config_field),
    .shutdown_state_ac(shutdown_state_ac),
    .pin_direction_bit(pin_direction_bit),
    .shutdown_condition(shutdown_condition), .sleep_mode(sleep_mode),
    .clock_fail_detect(clock_fail_detect), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d),
    .pwm_oe_a(pwm_oe_a), .pwm_oe_b(pwm_oe_b), .pwm_oe_c(pwm_oe_c),
    .pwm_oe_d(pwm_oe_d), .osc_fail_flag(osc_fail_flag), .irq(irq)
);
`default_nettype wire

//--- bench/psd_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module psd_bridge_model (
    // pins from the block
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // gate levels seen by the switch drivers
    output logic [3:0] level
);
    // pull-downs keep an undriven switch off
    assign level = pin_out & pin_oe;
endmodule // psd_bridge_model
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // design inputs, all valued at time zero
    logic clock = 0, resetn = 1, reg_write = 0, reg_read = 0;
    logic raw = 0, pstart = 0, sd_cond = 0, sleep = 0, cfail = 0;
    logic [3:0] reg_addr = 4'h0, mode = 4'hc, dir = 4'h0;
    logic [7:0] reg_wdata = 8'h00, s;
    logic [1:0] cfg = 2'h0, sd_bd = 2'h0, sd_ac = 2'h0;
    logic [7:0] dbs [2] = '{8'h00, 8'h03};
    // design outputs and resolved pin levels
    wire [7:0] reg_rdata;
    wire [3:0] po, oe, lvl;
    wire osc_fail_flag, irq;
    int errors = 0, cmp_count = 0, cyc = 0, n;

    psd_steer u_psd_steer (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .pwm_raw(raw),
        .period_start(pstart), .capture_compare_mode_field(mode),
        .output_config_field(cfg), .shutdown_state_ac(sd_ac),
        .shutdown_state_bd(sd_bd), .pin_direction_bit(dir),
        .shutdown_condition(sd_cond), .sleep_mode(sleep),
        .clock_fail_detect(cfail), .pwm_out_a(po[0]),
        .pwm_out_b(po[1]), .pwm_out_c(po[2]), .pwm_out_d(po[3]),
        .pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]),
        .pwm_oe_d(oe[3]), .osc_fail_flag(osc_fail_flag), .irq(irq)
    );
    psd_bridge_model u_psd_bridge_model (
        .pin_out(po), .pin_oe(oe), .level(lvl)
    );

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // cycle ceiling against a hung run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            final_report;
        end
    end

    // expected levels for steering word st and raw level r
    function automatic logic [3:0] want(input logic [7:0] st,
            input logic r);
        logic [1:0] p;
        p = st[7:6];
        want = {2{r ^ mode[0], r ^ mode[1]}};
        if (p != 2'h0)
            want[p] = ~want[p];
        want = want & ~dir & (p == 2'h0 ? st[3:0] : 4'h1 | 4'h1 << p);
    endfunction

    task automatic chk(input string what, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %0s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 0;
        #1 chk("reg", e, reg_rdata);
        @(posedge clock);
    endtask
    task automatic pins(input logic [3:0] e);
        repeat (6) @(posedge clock);
        #1 chk("pins", {4'h0, e}, {4'h0, lvl});
        @(posedge clock);
    endtask
    task automatic irq_is(input logic e);
        #1 chk("irq", {7'h0, e}, {7'h0, irq});
        @(posedge clock);
    endtask
    task automatic wait_a(input logic v);
        n = 0;
        while (lvl[0] !== v && n < 600) begin
            @(posedge clock);
            n++;
            #1;
        end
        @(posedge clock);
    endtask
    task automatic pulse;
        pstart <= 1;
        @(posedge clock);
        pstart <= 0;
    endtask
    task automatic tend(input string t);
        $display("test %0s done", t);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        resetn <= 0;
        n = $urandom(32'h7931);
        repeat (2) @(posedge clock);
        resetn <= 1;
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h01);
        rd(4'h7, 8'h00);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'hdf);
        tend("registers");
        // random steering words, polarity, direction and raw level
        repeat (10) begin
            s = 8'($urandom) & 8'hcf;
            raw <= 1'($urandom);
            mode <= {2'h3, 2'($urandom)};
            dir <= 4'($urandom);
            wr(4'h1, s);
            pins(want(s, raw));
        end
        raw <= 1;
        mode <= 4'h8;
        pins(4'h0);
        mode <= 4'hc;
        cfg <= 2'h1;
        dir <= 4'h0;
        pins(4'h0);
        cfg <= 2'h0;
        wr(4'h1, 8'h01);
        wr(4'h1, 8'h12);
        pins(4'h1);
        pulse();
        pins(4'h2);
        tend("steering");
        wr(4'h1, 8'h01);
        foreach (dbs[i]) begin
            wr(4'h0, dbs[i]);
            raw <= 0;
            repeat (4) @(posedge clock);
            raw <= 1;
            wait_a(1'b1);
            chk("rise", 8'(4 * dbs[i] + 2), 8'(n));
            raw <= 0;
            wait_a(1'b0);
            chk("fall", 8'h02, 8'(n));
        end
        tend("dead band");
        wr(4'h4, 8'h01);
        wr(4'h1, 8'h03);
        sd_bd <= 2'h1;
        raw <= 1;
        sd_cond <= 1;
        pins(4'h2);
        rd(4'h2, 8'h80);
        irq_is(1'b1);
        sd_cond <= 0;
        pins(4'h2);
        rd(4'h2, 8'h80);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h00);
        pins(4'h2);
        pulse();
        pins(4'h3);
        wr(4'h5, 8'h07);
        rd(4'h3, 8'h00);
        irq_is(1'b0);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h80);
        sd_ac <= 2'h1;
        raw <= 0;
        sd_cond <= 1;
        pins(4'h3);
        rd(4'h3, 8'h01);
        irq_is(1'b0);
        sd_cond <= 0;
        pins(4'h3);
        rd(4'h2, 8'h00);
        pulse();
        pins(4'h0);
        raw <= 1;
        pins(4'h3);
        tend("shutdown");
        sleep <= 1;
        raw <= 0;
        pins(4'h3);
        wr(4'h0, 8'h55);
        rd(4'h0, 8'h80);
        sleep <= 0;
        pins(4'h0);
        wr(4'h5, 8'h07);
        wr(4'h4, 8'h04);
        cfail <= 1;
        @(posedge clock);
        cfail <= 0;
        rd(4'h3, 8'h04);
        irq_is(1'b1);
        raw <= 1;
        pins(4'h3);
        resetn <= 0;
        #1 chk("oe", 8'h00, {4'h0, oe});
        @(posedge clock);
        resetn <= 1;
        rd(4'h0, 8'h00);
        tend("power and reset");
        final_report;
    end
endmodule // tb_top
`default_nettype wire
